// [updfp_dmac.sv]
// external dma controller model for the dma fifo port pins
module updfp_dmac (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // setup from the bench
    input  wire logic       en,
    input  wire logic [2:0] fmt,
    input  wire logic [3:0] dly,
    // dma pins
    input  wire logic       dma_request_n,
    output logic            dma_acknowledge_n,
    output logic            fifo_rd_n,
    output logic            fifo_wr_n,
    // strokes issued
    output int              strokes
);
    timeunit 1ns;
    timeprecision 1ps;

    // one stroke per seen request, held four cycles; no chip select is driven
    // dly sets the answer delay
    initial begin
        dma_acknowledge_n = 1'b1;
        fifo_rd_n = 1'b1;
        fifo_wr_n = 1'b1;
        strokes = 0;
        forever begin
            @(posedge mclk);
            if (reset_n && en && !dma_request_n) begin
                repeat (dly) @(posedge mclk);
                dma_acknowledge_n <= (fmt == 3'h0);
                fifo_rd_n <= (fmt == 3'h3 || fmt == 3'h6);
                strokes <= strokes + 1;
                repeat (4) @(posedge mclk);
                dma_acknowledge_n <= 1'b1;
                fifo_rd_n <= 1'b1;
                repeat (3) @(posedge mclk);
            end
        end
    end
endmodule : updfp_dmac

// [updfp_sw_if.sv]
// pipe switch handshake between the port core and the switch tracker
interface updfp_sw_if;
    logic       sel_write;
    logic [3:0] new_pipe;
    logic       buf_toggle;
    logic [3:0] shown_pipe;
    logic       busy;
    modport ctl (output sel_write, output new_pipe, output buf_toggle,
                 input shown_pipe, input busy);
    modport trk (input sel_write, input new_pipe, input buf_toggle,
                 output shown_pipe, output busy);
endinterface : updfp_sw_if

// [updfp_switch.sv]
// pipe switch and double buffer toggle tracker
`include "usb_pipe_dma_fifo_port_map.svh"
module updfp_switch (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // handshake with the port core
    updfp_sw_if.trk  sw
);
    import updfp_pkg::*;

    logic [3:0] pipe_reg;
    logic [3:0] target_reg;
    logic [5:0] count_reg;
    logic       start_switch;

    // a switch to the pipe already served costs nothing
    assign start_switch  = sw.sel_write && (sw.new_pipe != pipe_reg);
    assign sw.shown_pipe = pipe_reg;
    assign sw.busy       = (count_reg != 6'h00);

    // old pipe stays visible until the switch has settled
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pipe_reg   <= `UPDFP_PIPE_RST;
            target_reg <= `UPDFP_PIPE_RST;
            count_reg  <= 6'h00;
        end else if (start_switch) begin
            target_reg <= sw.new_pipe;
            count_reg  <= 6'(`UPDFP_SWITCH_CYC);
        end else if (sw.buf_toggle && (count_reg == 6'h00)) begin
            target_reg <= pipe_reg;
            count_reg  <= 6'(`UPDFP_TOGGLE_CYC);
        end else if (count_reg != 6'h00) begin
            count_reg <= count_reg - 6'h01;
            if (count_reg == 6'h01) begin
                pipe_reg <= target_reg; // [RQ20]
            end
        end
    end

    property p_switch_old;
        @(posedge mclk) disable iff (!reset_n)
        start_switch |=> (sw.shown_pipe == $past(sw.shown_pipe)) && sw.busy;
    endproperty
    a_switch_old: assert property (p_switch_old) else $error("old pipe not shown"); // [RQ20]

    property p_switch_len;
        @(posedge mclk) disable iff (!reset_n)
        (start_switch && (count_reg == 6'h00)) ##1 (!sw.sel_write [*8])
            |=> !sw.busy && (sw.shown_pipe == $past(sw.new_pipe, 9));
    endproperty
    a_switch_len: assert property (p_switch_len) else $error("switch length wrong"); // [RQ20]
endmodule : updfp_switch

// [usb_pipe_dma_fifo_port.sv]
// dma fifo port: request, acknowledge, transfer end, auto clear and ready timing
// Contract
// (RQ1) pipes one to nine may serve the port; request rises when that pipe is accessible
// (RQ2) cycle steal mode issues one request per byte or word moved
// (RQ3) burst mode holds the request until the buffer has been emptied
// (RQ4) a width bit picks 8 or 16 bit units; a field picks the served pipe
// (RQ5) software keeps the pipe selection fixed while a transfer runs
// (RQ6) format bits with request enable pick one of five access methods
// (RQ7) with acknowledge on the cpu bus, chip select stays high during port access
// (RQ8) transfer end pin drives on buffer reads and listens on buffer writes
// (RQ9) end mode 0 flags count end, short packet, zero packet; not plain ready
// (RQ10) end mode 1 flags count end, ready, short, zero into nonempty; not into empty
// (RQ11) a zero length packet into an empty buffer raises no request
// (RQ12) on writes an active transfer end edge commits the packet like write end
// (RQ13) auto clear set clears the pipe buffer once its received data is read
// (RQ14) without auto clear software clears after zero or deferred short packets
// (RQ15) auto clear only acts in the read direction
// (RQ16) ready timing 1 raises no buffer ready for a full packet
// (RQ17) ready timing 1 defers short and count end ready until read; 0 raises on receipt
// (RQ18) received length holds the last packet length before the ready event
// (RQ19) software keeps ready timing at 0 for write direction pipes
// (RQ20) during a pipe switch the old pipe reads back; software waits for port ready
// (RQ21) software waits the same way after a cpu port direction change
// (RQ22) after a double buffer toggle the accessor waits 300 ns
// (RQ23) after write end on an in pipe the accessor also waits 300 ns
// (RQ24) write end makes the data so far a complete packet ready to send
// (RQ25) request drops when request enable is 0 or the buffer is not accessible
`include "usb_pipe_dma_fifo_port_map.svh"
module usb_pipe_dma_fifo_port (
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    reset_n,
    // register port
    input  wire logic [7:0]              reg_addr,
    input  wire logic [15:0]             reg_wdata,
    input  wire logic                    reg_write,
    input  wire logic                    reg_read,
    output logic      [15:0]             reg_rdata,
    // pipe buffer side
    input  wire logic                    buf_accessible,
    input  wire logic                    buf_read_dir,
    input  wire logic                    buf_last_unit,
    input  wire logic                    buf_is_empty,
    input  wire logic                    buf_toggle,
    input  wire logic                    rx_full_pkt,
    input  wire logic                    rx_short_pkt,
    input  wire logic                    rx_zero_pkt,
    input  wire logic                    rx_count_end,
    input  wire logic [`UPDFP_LEN_W-1:0] rx_length,
    output logic                         buf_unit_taken,
    output logic                         buf_clear,
    output logic                         buf_commit,
    output logic      [3:0]              buf_pipe,
    output logic                         buf_unit_wide,
    output logic                         buffer_ready_event,
    // dma pins
    output logic                         dma_request_n,
    input  wire logic                    dma_acknowledge_n,
    input  wire logic                    fifo_rd_n,
    input  wire logic                    fifo_wr_n,
    input  wire logic                    transfer_end_pin_i,
    output logic                         transfer_end_pin_o,
    output logic                         transfer_end_pin_oe_n
);
    import updfp_pkg::*;

    updfp_sw_if sw ();

    updfp_switch u_switch (
        .mclk    (mclk),
        .reset_n (reset_n),
        .sw      (sw.trk)
    );

    // pipe zero belongs to the cpu port only
    function automatic logic pipe_ok(input logic [3:0] p);
        pipe_ok = (p >= 4'h1) && (p <= 4'h9);
    endfunction : pipe_ok

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] off);
        is_addr = (a == off);
    endfunction : is_addr

    // software state
    logic                    wide_reg;
    logic                    req_en_reg;
    logic                    auto_clr_reg;
    logic                    burst_reg;
    logic [2:0]              format_reg;
    logic                    end_mode_reg;
    logic                    rdy_time_reg;
    logic                    buffer_ready_event_flag_reg;
    logic [`UPDFP_LEN_W-1:0] length_reg;
    // transfer state
    logic                    gap_reg;
    logic                    last_done_reg;
    logic                    zero_empty_reg;
    logic                    end_pend_reg;
    logic                    defer_reg;
    // pins: meta stage, sync stage, previous sync value
    logic [3:0]              pin_meta_reg;
    logic [3:0]              pin_sync_reg;
    logic [3:0]              pin_prev_reg;

    // register decode
    logic wr_sel;
    logic wr_cfg;
    logic wr_ctr;
    logic wr_stat;
    logic sw_clear;
    logic sw_wr_end;
    assign wr_sel    = reg_write && is_addr(reg_addr, `UPDFP_OFF_SEL);
    assign wr_cfg    = reg_write && is_addr(reg_addr, `UPDFP_OFF_CFG);
    assign wr_ctr    = reg_write && is_addr(reg_addr, `UPDFP_OFF_CTR);
    assign wr_stat   = reg_write && is_addr(reg_addr, `UPDFP_OFF_STAT);
    assign sw_clear  = wr_ctr && reg_wdata[`UPDFP_CTR_CLEAR];
    assign sw_wr_end = wr_ctr && reg_wdata[`UPDFP_CTR_WREND];

    // switch tracker hookup; out of range pipes are never requested
    assign sw.sel_write  = wr_sel && pipe_ok(reg_wdata[3:0]); // [RQ1]
    assign sw.new_pipe   = reg_wdata[3:0]; // [RQ4] [RQ5]
    assign sw.buf_toggle = buf_toggle; // [RQ22]

    // access method from format and request enable
    updfp_method_type method;
    assign method = !req_en_reg            ? UPDFP_CPU_ONLY   :
                    (format_reg == 3'h0)   ? UPDFP_REQ_ONLY   :
                    (format_reg == 3'h2)   ? UPDFP_ACK_STROBE :
                    (format_reg == 3'h3)   ? UPDFP_ACK_ONLY   :
                    (format_reg == 3'h6)   ? UPDFP_SPLIT      : UPDFP_CPU_ONLY; // [RQ6]

    // synchronised pin views: bit 0 ack, 1 rd, 2 wr, 3 transfer end
    logic ack_act;
    logic ack_edge;
    logic strobe_edge;
    logic pins_idle;
    logic te_rise;
    assign ack_act     = !pin_sync_reg[0];
    assign ack_edge    = ack_act && pin_prev_reg[0];
    assign strobe_edge = (!pin_sync_reg[1] && pin_prev_reg[1]) ||
                         (!pin_sync_reg[2] && pin_prev_reg[2]);
    assign pins_idle   = pin_sync_reg[0] && pin_sync_reg[1] && pin_sync_reg[2];
    assign te_rise     = pin_sync_reg[3] && !pin_prev_reg[3];

    // a unit moves on the edge that the chosen method defines
    logic raw_take;
    logic unit_take;
    logic read_done;
    always_comb begin
        case (method)
            UPDFP_REQ_ONLY:   raw_take = strobe_edge;
            UPDFP_ACK_STROBE: raw_take = strobe_edge && ack_act; // [RQ7]
            UPDFP_ACK_ONLY:   raw_take = ack_edge;
            UPDFP_SPLIT:      raw_take = ack_edge;
            default:          raw_take = 1'b0;
        endcase
    end
    assign unit_take = raw_take && !dma_request_n;
    assign read_done = unit_take && buf_last_unit && buf_read_dir;

    // gap after a unit: steal mode waits for the bus to go idle, the last unit in either mode for the buffer
    logic gap_set;
    logic gap_next;
    logic last_next;
    assign gap_set   = unit_take && (!burst_reg || buf_last_unit); // [RQ2] [RQ3]
    assign last_next = gap_set ? buf_last_unit : last_done_reg;
    assign gap_next  = gap_set ? 1'b1 :
                       (gap_reg && (last_done_reg ? buf_accessible : !pins_idle));

    // request level
    logic req_next;
    logic zero_empty_ev;
    assign req_next = (method != UPDFP_CPU_ONLY) && buf_accessible && !sw.busy && // [RQ1]
                      !gap_reg && !gap_set && !zero_empty_reg && !zero_empty_ev; // [RQ11] [RQ25]

    // receive events and their end and ready consequences
    logic any_rx;
    logic end_ev;
    logic buffer_ready_event_now;
    logic buffer_ready_event_raise;
    logic auto_clear;
    assign any_rx        = rx_full_pkt || rx_short_pkt || rx_zero_pkt || rx_count_end;
    assign zero_empty_ev = rx_zero_pkt && buf_is_empty;
    assign end_ev        = buf_read_dir && (rx_count_end || rx_short_pkt ||
                           (rx_zero_pkt && !buf_is_empty) ||
                           (end_mode_reg ? rx_full_pkt : zero_empty_ev)); // [RQ9] [RQ10]
    assign buffer_ready_event_now      = rdy_time_reg ? rx_zero_pkt : any_rx; // [RQ16] [RQ17]
    assign buffer_ready_event_raise    = buffer_ready_event_now || (defer_reg && read_done); // [RQ17]
    assign auto_clear    = auto_clr_reg && buf_read_dir && (read_done || rx_zero_pkt); // [RQ13] [RQ15]

    // transfer end pin: drives on reads, marks the last unit
    logic te_out_next;
    assign te_out_next = buf_read_dir && end_pend_reg &&
                         ((req_next && buf_last_unit) || zero_empty_reg); // [RQ8] [RQ9]

    // readback mux; unmapped offsets read as zero
    logic [15:0] rd_mux;
    assign rd_mux = is_addr(reg_addr, `UPDFP_OFF_SEL)  ?
                        {8'h00, burst_reg, auto_clr_reg, req_en_reg, wide_reg, sw.shown_pipe} :
                    is_addr(reg_addr, `UPDFP_OFF_CFG)  ?
                        {11'h000, rdy_time_reg, end_mode_reg, format_reg} :
                    is_addr(reg_addr, `UPDFP_OFF_CTR)  ?
                        {2'b00, buf_accessible && !sw.busy, 2'b00, length_reg} :
                    is_addr(reg_addr, `UPDFP_OFF_STAT) ?
                        {13'h0000, end_pend_reg, !dma_request_n, buffer_ready_event_flag_reg} : 16'h0000;

    // pin synchronisers; only the sync and previous stages are looked at
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pin_meta_reg <= 4'h7;
            pin_sync_reg <= 4'h7;
            pin_prev_reg <= 4'h7;
        end else begin
            pin_meta_reg <= {transfer_end_pin_i, fifo_wr_n, fifo_rd_n, dma_acknowledge_n};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // software registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wide_reg     <= 1'b0;
            req_en_reg   <= 1'b0;
            auto_clr_reg <= 1'b0;
            burst_reg    <= 1'b0;
            format_reg   <= `UPDFP_FORMAT_RST;
            end_mode_reg <= 1'b0;
            rdy_time_reg <= 1'b0;
        end else begin
            if (wr_sel) begin
                wide_reg     <= reg_wdata[`UPDFP_SEL_WIDE]; // [RQ4]
                req_en_reg   <= reg_wdata[`UPDFP_SEL_REQEN];
                auto_clr_reg <= reg_wdata[`UPDFP_SEL_AUTOCLR];
                burst_reg    <= reg_wdata[`UPDFP_SEL_BURST];
            end
            if (wr_cfg) begin
                format_reg   <= reg_wdata[2:0];
                end_mode_reg <= reg_wdata[`UPDFP_CFG_ENDMODE];
                rdy_time_reg <= reg_wdata[`UPDFP_CFG_RDYTIME]; // [RQ19]
            end
        end
    end

    // ready flag: a new event beats a software clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            buffer_ready_event_flag_reg <= 1'b0;
            length_reg    <= '0;
        end else begin
            buffer_ready_event_flag_reg <= buffer_ready_event_raise ||
                             (buffer_ready_event_flag_reg && !(wr_stat && reg_wdata[`UPDFP_STAT_BUFFER_READY_EVENT]));
            if (any_rx && buf_read_dir) begin
                length_reg <= rx_length; // [RQ18]
            end
        end
    end

    // transfer state; clears lose to events arriving in the same cycle
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            gap_reg        <= 1'b0;
            last_done_reg  <= 1'b0;
            zero_empty_reg <= 1'b0;
            end_pend_reg   <= 1'b0;
            defer_reg      <= 1'b0;
        end else begin
            gap_reg        <= gap_next;
            last_done_reg  <= gap_next && last_next;
            zero_empty_reg <= zero_empty_ev || (zero_empty_reg && !buf_clear); // [RQ11]
            end_pend_reg   <= end_ev || (end_pend_reg && !read_done && !buf_clear);
            defer_reg      <= (rdy_time_reg && (rx_short_pkt || rx_count_end)) ||
                              (defer_reg && !read_done && !buf_clear); // [RQ17]
        end
    end

    // registered outputs
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            reg_rdata             <= 16'h0000;
            dma_request_n         <= 1'b1;
            buf_unit_taken        <= 1'b0;
            buf_clear             <= 1'b0;
            buf_commit            <= 1'b0;
            buf_pipe              <= `UPDFP_PIPE_RST;
            buf_unit_wide         <= 1'b0;
            buffer_ready_event    <= 1'b0;
            transfer_end_pin_o    <= 1'b0;
            transfer_end_pin_oe_n <= 1'b1;
        end else begin
            reg_rdata             <= reg_read ? rd_mux : 16'h0000;
            dma_request_n         <= !req_next; // [RQ2] [RQ3] [RQ25]
            buf_unit_taken        <= unit_take;
            buf_clear             <= sw_clear || auto_clear; // [RQ13] [RQ15]
            buf_commit            <= !buf_read_dir && (te_rise || sw_wr_end); // [RQ12] [RQ24]
            buf_pipe              <= sw.shown_pipe;
            buf_unit_wide         <= wide_reg; // [RQ4]
            buffer_ready_event    <= buffer_ready_event_raise;
            transfer_end_pin_o    <= te_out_next;
            transfer_end_pin_oe_n <= !buf_read_dir; // [RQ8]
        end
    end

    property p_req_disable;
        @(posedge mclk) disable iff (!reset_n)
        (!req_en_reg || !buf_accessible) |=> dma_request_n;
    endproperty
    a_req_disable: assert property (p_req_disable) else $error("request while disabled"); // [RQ25]

    property p_steal_gap;
        @(posedge mclk) disable iff (!reset_n)
        (unit_take && !burst_reg) |=> dma_request_n;
    endproperty
    a_steal_gap: assert property (p_steal_gap) else $error("steal request held"); // [RQ2]

    property p_burst_hold;
        @(posedge mclk) disable iff (!reset_n)
        (burst_reg && !dma_request_n && buf_accessible && !buf_last_unit && !sw.busy &&
         (method != UPDFP_CPU_ONLY) && !zero_empty_reg && !zero_empty_ev) |=> !dma_request_n;
    endproperty
    a_burst_hold: assert property (p_burst_hold) else $error("burst request dropped"); // [RQ3]

    property p_zero_empty;
        @(posedge mclk) disable iff (!reset_n)
        (rx_zero_pkt && buf_is_empty && !buf_clear) |=> dma_request_n [*2];
    endproperty
    a_zero_empty: assert property (p_zero_empty) else $error("request on empty zero packet"); // [RQ11]

    property p_end_commit;
        @(posedge mclk) disable iff (!reset_n)
        (!buf_read_dir && te_rise) |=> buf_commit;
    endproperty
    a_end_commit: assert property (p_end_commit) else $error("end edge not committed"); // [RQ12]

    property p_auto_clear;
        @(posedge mclk) disable iff (!reset_n)
        (auto_clr_reg && read_done) |=> buf_clear;
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("auto clear missing"); // [RQ13]

    property p_clear_dir;
        @(posedge mclk) disable iff (!reset_n)
        (!buf_read_dir && !sw_clear) |=> !buf_clear;
    endproperty
    a_clear_dir: assert property (p_clear_dir) else $error("clear in write direction"); // [RQ15]

    property p_full_quiet;
        @(posedge mclk) disable iff (!reset_n)
        (rdy_time_reg && rx_full_pkt && !rx_zero_pkt && !read_done) |=> !buffer_ready_event;
    endproperty
    a_full_quiet: assert property (p_full_quiet) else $error("ready on full packet"); // [RQ16]

    property p_pin_dir;
        @(posedge mclk) disable iff (!reset_n)
        $changed(buf_read_dir) |=> (transfer_end_pin_oe_n == !$past(buf_read_dir));
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("end pin direction wrong"); // [RQ8]
endmodule : usb_pipe_dma_fifo_port

// [usb_pipe_dma_fifo_port_bench.sv]
// self-checking bench for the dma fifo port
`include "usb_pipe_dma_fifo_port_map.svh"
module usb_pipe_dma_fifo_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 0, reset_n = 0, reg_write = 0, reg_read = 0, dm_en = 0, rq = 1;
    logic        buf_accessible = 0, buf_read_dir = 1, buf_last_unit = 0, buf_is_empty = 0;
    logic        buf_toggle = 0, transfer_end_pin_i = 0;
    logic [3:0]  rx = 0, dly = 0, buf_pipe;
    logic [2:0]  fmt = 0;
    logic [2:0]  fm [5] = '{3'h1, 3'h0, 3'h2, 3'h6, 3'h3};
    logic [7:0]  reg_addr = 0;
    logic [15:0] reg_wdata = 0, reg_rdata, d;
    logic [10:0] rx_length = 0;
    logic        buf_unit_taken, buf_clear, buf_commit, buf_unit_wide, buffer_ready_event;
    logic        dma_request_n, dma_acknowledge_n, fifo_rd_n, fifo_wr_n;
    logic        transfer_end_pin_o, transfer_end_pin_oe_n;
    int          failures = 0, cmp_count = 0, seed = 32'h1746, p, strokes, t0, s0, r0;
    int          n_take = 0, n_rise = 0, n_rdy = 0, n_clr = 0, n_com = 0;

    usb_pipe_dma_fifo_port u_dut (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .buf_accessible, .buf_read_dir, .buf_last_unit,
        .buf_is_empty, .buf_toggle, .rx_full_pkt(rx[0]), .rx_short_pkt(rx[1]),
        .rx_zero_pkt(rx[2]), .rx_count_end(rx[3]), .rx_length, .buf_unit_taken,
        .buf_clear, .buf_commit, .buf_pipe, .buf_unit_wide, .buffer_ready_event,
        .dma_request_n, .dma_acknowledge_n, .fifo_rd_n, .fifo_wr_n,
        .transfer_end_pin_i, .transfer_end_pin_o, .transfer_end_pin_oe_n);
    updfp_dmac u_dmac (.mclk, .reset_n, .en(dm_en), .fmt, .dly, .dma_request_n,
        .dma_acknowledge_n, .fifo_rd_n, .fifo_wr_n, .strokes);

    // clock, and pulse tallies taken before each edge's updates land
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        n_take += buf_unit_taken;
        n_rdy += buffer_ready_event;
        n_clr += buf_clear;
        n_com += buf_commit;
        if (dma_request_n && !rq) n_rise++;
        rq = dma_request_n;
    end

    task cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task stop_test;
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test

    task wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a);
        @(posedge mclk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // bounded poll of port ready; running out ends the run
    task wait_ready;
        for (int i = 0; i < 40; i++) begin
            rd(`UPDFP_OFF_CTR);
            if (d[13] === 1'b1) return;
        end
        failures++;
        stop_test;
    endtask : wait_ready

    task ev(input int k);
        @(posedge mclk);
        rx[k] <= 1'b1;
        @(posedge mclk);
        rx <= 4'h0;
    endtask : ev

    initial begin
        cyc(8);
        reset_n <= 1'b1;
        rd(`UPDFP_OFF_SEL);
        chk(d, 16'h0001);
        rd(8'h10);
        chk(d, 16'h0000);
        buf_accessible <= 1'b1;
        p = 1 + {$random(seed)} % 9;
        wr(`UPDFP_OFF_SEL, 16'(p));
        rd(`UPDFP_OFF_SEL);
        chk(d, 16'h0001);
        wait_ready;
        wr(`UPDFP_OFF_SEL, 16'h001a);
        wait_ready;
        rd(`UPDFP_OFF_SEL);
        chk(d, 16'(p) | 16'h0010);
        chk(buf_pipe, 16'(p));
        chk(buf_unit_wide, 16'h1);
        // every pin format; pipe select stays put while a transfer runs
        foreach (fm[i]) begin
            fmt <= fm[i];
            dly <= 4'($random(seed));
            wr(`UPDFP_OFF_CFG, 16'(fm[i]));
            wr(`UPDFP_OFF_SEL, 16'(p) | 16'h0020);
            wait_ready;
            t0 = n_take;
            s0 = strokes;
            r0 = n_rise;
            dm_en <= 1'b1;
            cyc(60);
            dm_en <= 1'b0;
            cyc(40);
            chk(16'(n_take - t0), 16'(strokes - s0));
            chk(16'(n_rise - r0), 16'(n_take - t0));
            chk(16'(n_take > t0), 16'(fm[i] != 3'h1));
        end
        // burst holds the request until the last unit
        wr(`UPDFP_OFF_SEL, 16'(p) | 16'h00a0);
        wait_ready;
        t0 = n_take;
        r0 = n_rise;
        dm_en <= 1'b1;
        cyc(80);
        chk(16'(n_rise - r0), 16'h0);
        chk(16'(n_take - t0 > 1), 16'h1);
        buf_last_unit <= 1'b1;
        cyc(40);
        dm_en <= 1'b0;
        chk(dma_request_n, 16'h1);
        buf_accessible <= 1'b0;
        buf_last_unit <= 1'b0;
        cyc(40);
        chk(dma_request_n, 16'h1);
        // zero packet into an empty buffer under both end modes
        buf_accessible <= 1'b1;
        buf_is_empty <= 1'b1;
        wr(`UPDFP_OFF_SEL, 16'(p) | 16'h0020);
        chk(transfer_end_pin_oe_n, 16'h0);
        for (int m = 0; m < 2; m++) begin
            wr(`UPDFP_OFF_CFG, 16'(m * 8 + 3));
            t0 = n_clr;
            r0 = n_rdy;
            ev(2);
            cyc(3);
            chk(transfer_end_pin_o, 16'(m == 0));
            chk(dma_request_n, 16'h1);
            chk(16'(n_rdy - r0), 16'h1);
            wr(`UPDFP_OFF_CTR, 16'h4000);
            cyc(2);
            chk(16'(n_clr - t0), 16'h1);
        end
        // ready event timing and received length
        buf_is_empty <= 1'b0;
        for (int r = 0; r < 2; r++) begin
            wr(`UPDFP_OFF_CFG, 16'(r * 16 + 3));
            rx_length <= 11'($random(seed));
            r0 = n_rdy;
            ev(0);
            ev(1);
            ev(3);
            cyc(3);
            chk(16'(n_rdy - r0), 16'(r == 0 ? 3 : 0));
            rd(`UPDFP_OFF_CTR);
            chk(d[10:0], rx_length);
            wr(`UPDFP_OFF_CTR, 16'h4000);
        end
        // auto clear acts in the read direction only
        wr(`UPDFP_OFF_CFG, 16'h0003);
        wr(`UPDFP_OFF_SEL, 16'(p) | 16'h0060);
        buf_is_empty <= 1'b1;
        for (int w = 0; w < 2; w++) begin
            buf_read_dir <= (w == 0);
            cyc(2);
            t0 = n_clr;
            ev(2);
            cyc(3);
            chk(16'(n_clr - t0), 16'(w == 0));
        end
        // write direction: end pin edge and write end both commit
        chk(transfer_end_pin_oe_n, 16'h1);
        t0 = n_com;
        transfer_end_pin_i <= 1'b1;
        cyc(6);
        chk(16'(n_com - t0), 16'h1);
        transfer_end_pin_i <= 1'b0;
        wr(`UPDFP_OFF_CTR, 16'h8000);
        cyc(30);
        chk(16'(n_com - t0), 16'h2);
        // a double buffer toggle holds port ready low for a while
        buf_toggle <= 1'b1;
        cyc(1);
        buf_toggle <= 1'b0;
        rd(`UPDFP_OFF_CTR);
        chk(d[13], 16'h0);
        wait_ready;
        stop_test;
    end
endmodule : usb_pipe_dma_fifo_port_bench

// [usb_pipe_dma_fifo_port_map.svh]
// register offsets, field positions, reset values and timing counts of the dma fifo port
`ifndef UPDFP_MAP_SVH
`define UPDFP_MAP_SVH

// register byte offsets, one aligned word each
`define UPDFP_OFF_SEL      8'h00
`define UPDFP_OFF_CFG      8'h04
`define UPDFP_OFF_CTR      8'h08
`define UPDFP_OFF_STAT     8'h0c

// select register fields
`define UPDFP_SEL_WIDE     4
`define UPDFP_SEL_REQEN    5
`define UPDFP_SEL_AUTOCLR  6
`define UPDFP_SEL_BURST    7

// config register fields
`define UPDFP_CFG_ENDMODE  3
`define UPDFP_CFG_RDYTIME  4

// control register fields
`define UPDFP_CTR_WREND    15
`define UPDFP_CTR_CLEAR    14

// status register fields
`define UPDFP_STAT_BUFFER_READY_EVENT    0

// reset values
`define UPDFP_PIPE_RST     4'h1
`define UPDFP_FORMAT_RST   3'h0

// timing
`define UPDFP_CLK_NS       10
`define UPDFP_TOGGLE_NS    300
`define UPDFP_TOGGLE_CYC   ((`UPDFP_TOGGLE_NS + `UPDFP_CLK_NS - 1) / `UPDFP_CLK_NS)
`define UPDFP_SWITCH_CYC   8
`define UPDFP_LEN_W        11

`endif

// [usb_pipe_dma_fifo_port_pkg.sv]
// types shared by the dma fifo port modules
package updfp_pkg;
    typedef enum logic [2:0] {
        UPDFP_CPU_ONLY,
        UPDFP_REQ_ONLY,
        UPDFP_ACK_STROBE,
        UPDFP_ACK_ONLY,
        UPDFP_SPLIT
    } updfp_method_type;
endpackage : updfp_pkg
